/* File: auto_restart_flying_start_ctl.sv */
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "restart_ctl_params.svh"
// Overview of operation
// - Restart mode decodes values 0 to 6 into distinct restart behaviours.
// - Mode resets to 1; attempt limit applies only in modes 3 and 4.
// - Attempt limit accepts 0 to 10 and resets to 3.
// - On power return with restart enabled, clear faults then switch on.
// - Power-return restart needs the ON command still present.
// - Mode 6 clears faults and starts on every power-up and ON command.
// - Undervoltage keeps control supply; power failure resets the control logic.
// - Fault-restart modes acknowledge and restart after a trip, until mode 3 reaches its attempt limit and locks.
// - Catch setting decodes disabled, every start, power-on/fault/coast, fault/coast.
// - Catch settings 1-3 sweep both directions, 4-6 setpoint direction only.
// - Catch sweeps frequency until speed found or the sweep runs out, then ramps normally.
// - Mode 1 clears faults without starting, except that it starts when an undervoltage is pending.
// - Catch is inactive while holding brake select equals 1.
module auto_restart_flying_start_ctl #(
    parameter int FREQ_W   = 16,
    parameter int FREQ_MAX = 16'hffff,
    parameter int FREQ_STEP = 16'h0100
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              on_cmd_i,
    input  wire logic              coast_stop_command_i,
    input  wire logic              line_ok_i,
    input  wire logic              fault_i,
    input  wire logic              speed_found_i,
    input  wire logic              at_setpoint_i,
    output logic                   run_o,
    output logic                   fault_ack_o,
    output logic                   search_o,
    output logic                   reverse_o,
    output logic [FREQ_W-1:0]      freq_o,
    output logic                   ramp_o,
    output logic                   irq_o
);
    restart_ctl_pkg::wb_req_t req;
    restart_ctl_pkg::cfg_t    cfg_ff;
    restart_ctl_pkg::state_t  state_ff;
    restart_ctl_pkg::state_t  nxt_state;
    restart_ctl_pkg::cause_t  cause_ff;
    restart_ctl_pkg::mode_t   mf;
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    logic       on_s;
    logic       coast_s;
    logic       line_s;
    logic       flt_s;
    logic       found_s;
    logic       on_d_ff;
    logic       line_d_ff;
    logic       uv_pend_ff;
    logic [1:0] pu_cnt_ff;
    logic [3:0] tries_ff;
    logic       both_dir_ff;
    logic       second_ff;
    logic [3:0] irq_sts_ff;
    logic [3:0] irq_mask_ff;
    logic [3:0] irq_ev;
    logic       wr;
    logic       rd_ok;
    logic       catch_en;
    logic       lock_now;

    // Decodes the restart mode into per-event actions.
    function automatic restart_ctl_pkg::mode_t mode_dec(input logic [2:0] m);
        restart_ctl_pkg::mode_t f;
        f = '0;
        case (m)
            3'h1: f.pf_ack = 1'b1;
            3'h2: begin
                f.pf_ack   = 1'b1;
                f.pf_start = 1'b1;
            end
            3'h3: begin
                f = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            end
            3'h4: begin
                f = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
            end
            3'h5: begin
                f = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
            end
            3'h6: begin
                f = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
            end
            default: f = '0;
        endcase
        return f;
    endfunction

    // Decides whether the catch applies to a start of the given cause.
    function automatic logic catch_dec(input logic [2:0] s,
                                       input restart_ctl_pkg::cause_t c);
        logic en;
        en = 1'b0;
        case (s)
            3'h1, 3'h4: en = 1'b1;
            3'h2, 3'h5: en = (c != restart_ctl_pkg::CS_NORMAL);
            3'h3, 3'h6: en = (c == restart_ctl_pkg::CS_FAULT) ||
                             (c == restart_ctl_pkg::CS_COAST);
            default: en = 1'b0;
        endcase
        return en;
    endfunction

    assign req = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i};
    assign mf = mode_dec(cfg_ff.mode);
    assign catch_en = catch_dec(cfg_ff.catch_sel, cause_ff) &&
                      (cfg_ff.brake_sel != 2'h1);
    assign lock_now = mf.limited && (tries_ff + 4'h1 >= cfg_ff.limit);

    // Two-stage synchronisers for every pin input except at_setpoint_i.
    always_ff @(posedge clk_i) begin
        sync1_ff <= {on_cmd_i, coast_stop_command_i, line_ok_i, fault_i,
                     speed_found_i};
        sync2_ff <= sync1_ff;
    end
    assign {on_s, coast_s, line_s, flt_s, found_s} = sync2_ff;

    // Edge history of the ON command and motor supply.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            on_d_ff   <= 1'b0;
            line_d_ff <= 1'b0;
        end else begin
            on_d_ff   <= on_s;
            line_d_ff <= line_s;
        end
    end

    // Bus write decoding and register file.
    assign wr = req.cyc && req.stb && req.we && !wb_ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_ff.mode      <= `RC_MODE_RST;
            cfg_ff.catch_sel <= `RC_CATCH_RST;
            cfg_ff.brake_sel <= `RC_BRAKE_RST;
            cfg_ff.limit     <= `RC_LIMIT_RST;
            irq_mask_ff      <= 4'h0;
        end else if (wr) begin
            if (req.adr == `RC_OFS_CTRL && req.sel[0]) begin
                cfg_ff.mode      <= (req.dat[2:0] > 3'h6) ? cfg_ff.mode
                                                          : req.dat[2:0];
                cfg_ff.catch_sel <= (req.dat[6:4] > 3'h6) ? cfg_ff.catch_sel
                                                          : req.dat[6:4];
            end
            if (req.adr == `RC_OFS_CTRL && req.sel[1]) begin
                cfg_ff.brake_sel <= req.dat[9:8];
            end
            if (req.adr == `RC_OFS_LIMIT && req.sel[0]) begin
                cfg_ff.limit <= (req.dat[3:0] > `RC_LIMIT_MAX) ?
                                `RC_LIMIT_MAX : req.dat[3:0];
            end
            if (req.adr == `RC_OFS_IRQ_MASK && req.sel[0]) begin
                irq_mask_ff <= req.dat[3:0];
            end
        end
    end

    // Read data and acknowledge, one cycle after the request.
    always_comb begin
        rd_ok = 1'b1;
        case (req.adr)
            `RC_OFS_CTRL, `RC_OFS_LIMIT, `RC_OFS_STATUS,
            `RC_OFS_IRQ_STS, `RC_OFS_IRQ_MASK: rd_ok = 1'b1;
            default: rd_ok = 1'b0;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
            wb_dat_o <= 32'h0;
            case (req.adr)
                `RC_OFS_CTRL:     wb_dat_o <= {22'h0, cfg_ff.brake_sel, 1'b0,
                                     cfg_ff.catch_sel, 1'b0, cfg_ff.mode};
                `RC_OFS_LIMIT:    wb_dat_o <= {28'h0, cfg_ff.limit};
                `RC_OFS_STATUS:   wb_dat_o <= {24'h0, tries_ff, uv_pend_ff,
                                     state_ff};
                `RC_OFS_IRQ_STS:  wb_dat_o <= {28'h0, irq_sts_ff};
                `RC_OFS_IRQ_MASK: wb_dat_o <= {28'h0, irq_mask_ff};
                default:          wb_dat_o <= rd_ok ? 32'h0 : 32'h0;
            endcase
        end
    end

    // Next state of the restart sequencer.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            restart_ctl_pkg::ST_POWERUP: begin
                if (pu_cnt_ff == 2'h0) begin
                    if (mf.pf_start && on_s && line_s) begin
                        nxt_state = restart_ctl_pkg::ST_ACK;
                    end else if (mf.pf_ack) begin
                        nxt_state = restart_ctl_pkg::ST_ACK;
                    end else begin
                        nxt_state = restart_ctl_pkg::ST_IDLE;
                    end
                end
            end
            restart_ctl_pkg::ST_IDLE: begin
                if (line_s && !line_d_ff && uv_pend_ff && mf.uv_restart &&
                    on_s) begin
                    nxt_state = restart_ctl_pkg::ST_ACK;
                end else if (on_s && !on_d_ff && line_s) begin
                    nxt_state = (cfg_ff.mode == 3'h6) ?
                        restart_ctl_pkg::ST_ACK : restart_ctl_pkg::ST_START;
                end
            end
            restart_ctl_pkg::ST_ACK: begin
                // mode 1 acks without starting unless an undervoltage is pending
                // A start waits until the fault store shows the clear.
                if (cfg_ff.mode == 3'h1 && !uv_pend_ff) begin
                    nxt_state = restart_ctl_pkg::ST_IDLE;
                end else if (!flt_s) begin
                    nxt_state = restart_ctl_pkg::ST_START;
                end
            end
            restart_ctl_pkg::ST_START: begin
                if (flt_s) begin
                    nxt_state = restart_ctl_pkg::ST_IDLE;
                end else begin
                    nxt_state = catch_en ? restart_ctl_pkg::ST_SEARCH
                                         : restart_ctl_pkg::ST_RAMP;
                end
            end
            restart_ctl_pkg::ST_SEARCH, restart_ctl_pkg::ST_RAMP: begin
                if (flt_s) begin
                    nxt_state = lock_now ? restart_ctl_pkg::ST_LOCKED
                                         : restart_ctl_pkg::ST_ACK;
                end else if (!line_s || !on_s || coast_s) begin
                    nxt_state = restart_ctl_pkg::ST_IDLE;
                end else if (state_ff == restart_ctl_pkg::ST_SEARCH &&
                             (found_s || (freq_o < FREQ_W'(FREQ_STEP) &&
                              (second_ff || !both_dir_ff)))) begin
                    nxt_state = restart_ctl_pkg::ST_RAMP;
                end else if (state_ff == restart_ctl_pkg::ST_RAMP &&
                             at_setpoint_i) begin
                    nxt_state = restart_ctl_pkg::ST_RUN;
                end
            end
            restart_ctl_pkg::ST_RUN: begin
                if (flt_s) begin
                    nxt_state = mf.flt_restart ? restart_ctl_pkg::ST_ACK
                                               : restart_ctl_pkg::ST_IDLE;
                end else if (!line_s || !on_s || coast_s) begin
                    nxt_state = restart_ctl_pkg::ST_IDLE;
                end
            end
            restart_ctl_pkg::ST_LOCKED: begin
                if (!on_s) begin
                    nxt_state = restart_ctl_pkg::ST_IDLE;
                end
            end
            default: nxt_state = restart_ctl_pkg::ST_IDLE;
        endcase
    end

    // State, power-up settle count and start cause.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff  <= restart_ctl_pkg::ST_POWERUP;
            pu_cnt_ff <= `RC_PU_WAIT;
            cause_ff  <= restart_ctl_pkg::CS_POWER_ON;
        end else begin
            state_ff <= nxt_state;
            if (pu_cnt_ff != 2'h0) begin
                pu_cnt_ff <= pu_cnt_ff - 2'h1;
            end
            if (flt_s) begin
                cause_ff <= restart_ctl_pkg::CS_FAULT;
            end else if (coast_s) begin
                cause_ff <= restart_ctl_pkg::CS_COAST;
            end else if (state_ff == restart_ctl_pkg::ST_RUN) begin
                cause_ff <= restart_ctl_pkg::CS_NORMAL;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uv_pend_ff <= 1'b0;
        end else if (!line_s && line_d_ff) begin
            uv_pend_ff <= 1'b1;
        end else if (state_ff == restart_ctl_pkg::ST_RUN ||
                     (on_s && !on_d_ff && line_s)) begin
            uv_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || state_ff == restart_ctl_pkg::ST_RUN ||
            state_ff == restart_ctl_pkg::ST_IDLE) begin
            tries_ff <= 4'h0;
        end else if (flt_s && mf.limited &&
                     (state_ff == restart_ctl_pkg::ST_SEARCH ||
                      state_ff == restart_ctl_pkg::ST_RAMP)) begin
            tries_ff <= tries_ff + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || state_ff != restart_ctl_pkg::ST_SEARCH) begin
            freq_o      <= FREQ_W'(FREQ_MAX);
            reverse_o   <= 1'b0;
            second_ff   <= 1'b0;
            both_dir_ff <= (cfg_ff.catch_sel < 3'h4);
        end else if (!found_s) begin
            if (freq_o >= FREQ_W'(FREQ_STEP)) begin
                freq_o <= freq_o - FREQ_W'(FREQ_STEP);
            end else if (both_dir_ff && !second_ff) begin
                freq_o    <= FREQ_W'(FREQ_MAX);
                reverse_o <= 1'b1;
                second_ff <= 1'b1;
            end
        end
    end

    // Drive outputs, registered from the next state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_o       <= 1'b0;
            fault_ack_o <= 1'b0;
            search_o    <= 1'b0;
            ramp_o      <= 1'b0;
        end else begin
            run_o    <= (nxt_state == restart_ctl_pkg::ST_SEARCH) ||
                        (nxt_state == restart_ctl_pkg::ST_RAMP) ||
                        (nxt_state == restart_ctl_pkg::ST_RUN);
            fault_ack_o <= (nxt_state == restart_ctl_pkg::ST_ACK) &&
                           (state_ff != restart_ctl_pkg::ST_ACK);
            search_o <= (nxt_state == restart_ctl_pkg::ST_SEARCH);
            ramp_o   <= (nxt_state == restart_ctl_pkg::ST_RAMP);
        end
    end

    // Sticky interrupt status, set wins over write-one-to-clear.
    assign irq_ev = {!line_s && line_d_ff,
                     state_ff != restart_ctl_pkg::ST_LOCKED &&
                     nxt_state == restart_ctl_pkg::ST_LOCKED,
                     state_ff == restart_ctl_pkg::ST_ACK,
                     state_ff != restart_ctl_pkg::ST_RUN &&
                     nxt_state == restart_ctl_pkg::ST_RUN};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_sts_ff <= 4'h0;
        end else if (wr && req.adr == `RC_OFS_IRQ_STS && req.sel[0]) begin
            irq_sts_ff <= (irq_sts_ff & ~req.dat[3:0]) | irq_ev;
        end else begin
            irq_sts_ff <= irq_sts_ff | irq_ev;
        end
    end
    assign irq_o = |(irq_sts_ff & irq_mask_ff);

    a_mode_reset_val: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> cfg_ff.mode == 3'h1 && cfg_ff.limit == 4'h3)
        else $error("mode or limit reset value wrong");
    a_limit_in_range: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_ff.limit <= 4'ha)
        else $error("attempt limit above ten");
    a_brake_no_catch: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == restart_ctl_pkg::ST_SEARCH |-> cfg_ff.brake_sel != 2'h1)
        else $error("catch ran with brake select one");
    a_lock_at_limit: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(state_ff == restart_ctl_pkg::ST_LOCKED) |->
        (cfg_ff.mode == 3'h3 || cfg_ff.mode == 3'h4))
        else $error("locked outside limited modes");
    a_ack_then_start: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == restart_ctl_pkg::ST_ACK && cfg_ff.mode == 3'h6 &&
        !flt_s |=>
        state_ff == restart_ctl_pkg::ST_START)
        else $error("mode 6 did not start after ack");
    a_mode1_no_run: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == restart_ctl_pkg::ST_ACK && cfg_ff.mode == 3'h1 &&
        !uv_pend_ff |=> state_ff == restart_ctl_pkg::ST_IDLE)
        else $error("mode 1 started after ack");
    a_search_one_dir: assert property (@(posedge clk_i) disable iff (rst_i)
        search_o && cfg_ff.catch_sel > 3'h3 && $stable(cfg_ff) |-> !reverse_o)
        else $error("reverse sweep with one-direction catch");
    a_ack_pulse_once: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_ack_o |=> !fault_ack_o)
        else $error("fault ack longer than one cycle");
    a_wb_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack not next cycle");
endmodule
`default_nettype wire

/* File: motor_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Motor and power stage seen from the control block.
module motor_stage_model #(
    parameter int FREQ_W   = 16,
    parameter int RAMP_CYC = 6
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              search_i,
    input  wire logic              ramp_i,
    input  wire logic [FREQ_W-1:0] freq_i,
    input  wire logic [FREQ_W-1:0] shaft_i,
    output logic                   speed_found_o,
    output logic                   at_setpoint_o
);
    int ramp_cnt;
    // speed located
    // The shaft is found once the sweep falls to its frequency.
    always_ff @(posedge clk_i) begin
        speed_found_o <= !rst_i && search_i && (freq_i <= shaft_i);
    end
    // normal ramp
    // Setpoint is reached a fixed ramp time after the ramp starts.
    always_ff @(posedge clk_i) begin
        if (rst_i || !ramp_i) begin
            ramp_cnt <= 0;
        end else if (ramp_cnt < RAMP_CYC) begin
            ramp_cnt <= ramp_cnt + 1;
        end
        at_setpoint_o <= ramp_i && (ramp_cnt == RAMP_CYC);
    end
endmodule
`default_nettype wire

/* File: restart_ctl_params.svh */
`ifndef RESTART_CTL_PARAMS_SVH
`define RESTART_CTL_PARAMS_SVH
// Register byte offsets on the Wishbone slave.
`define RC_OFS_CTRL      8'h00
`define RC_OFS_LIMIT     8'h04
`define RC_OFS_STATUS    8'h08
`define RC_OFS_IRQ_STS   8'h0c
`define RC_OFS_IRQ_MASK  8'h10
// Control register field positions.
`define RC_MODE_LSB      0
`define RC_CATCH_LSB     4
`define RC_BRAKE_LSB     8
// Reset values and limits.
`define RC_MODE_RST      3'h1
`define RC_CATCH_RST     3'h0
`define RC_BRAKE_RST     2'h0
`define RC_LIMIT_RST     4'h3
`define RC_LIMIT_MAX     4'ha
// Interrupt status bit positions.
`define RC_IRQ_RUN       0
`define RC_IRQ_ACK       1
`define RC_IRQ_LOCK      2
`define RC_IRQ_UV        3
// Cycles allowed for the pin synchronisers to settle after reset.
`define RC_PU_WAIT       2'h3
`endif

/* File: restart_ctl_pkg.sv */
package restart_ctl_pkg;
    typedef enum logic [2:0] {
        ST_POWERUP, ST_IDLE, ST_ACK, ST_START,
        ST_SEARCH, ST_RAMP, ST_RUN, ST_LOCKED
    } state_t;
    // Cause of a start, used by the spinning-motor catch decode.
    typedef enum logic [1:0] {
        CS_NORMAL, CS_POWER_ON, CS_FAULT, CS_COAST
    } cause_t;
    typedef struct packed {
        logic [2:0] mode;
        logic [2:0] catch_sel;
        logic [1:0] brake_sel;
        logic [3:0] limit;
    } cfg_t;
    // What a restart mode does for each kind of event.
    typedef struct packed {
        logic pf_ack;
        logic pf_start;
        logic uv_restart;
        logic flt_restart;
        logic limited;
    } mode_t;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;
endpackage

/* File: tb_auto_restart_flying_start_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "restart_ctl_params.svh"
module tb_auto_restart_flying_start_ctl;
    logic        clk_i, rst_i, cyc, stb, we, ack, on, line_ok, fault;
    logic        found, at_sp, run, fack, srch, rev, ramp, irq, s_srch, s_rev;
    logic        trip;
    logic [7:0]  adr;
    logic [31:0] wdat, dat_o, rd;
    logic [15:0] freq, shaft;
    int          n_mismatch, compares;
    int          catch_t[3] = '{1, 4, 1};
    int          brk_t[3] = '{0, 0, 1};
    int          shaft_t[3] = '{0, 'h200, 0};
    // Device, shortened sweep for a short run.
    auto_restart_flying_start_ctl #(.FREQ_MAX(16'h0400), .FREQ_STEP(16'h0100))
    i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .on_cmd_i(on),
        .coast_stop_command_i(1'b0), .line_ok_i(line_ok), .fault_i(fault),
        .speed_found_i(found), .at_setpoint_i(at_sp), .run_o(run),
        .fault_ack_o(fack), .search_o(srch), .reverse_o(rev), .freq_o(freq),
        .ramp_o(ramp), .irq_o(irq));
    motor_stage_model i_motor (.clk_i(clk_i), .rst_i(rst_i), .search_i(srch),
        .ramp_i(ramp), .freq_i(freq), .shaft_i(shaft),
        .speed_found_o(found), .at_setpoint_o(at_sp));
    // Fault store: a trip while driving latches a fault until acknowledged.
    always @(posedge clk_i) begin
        if (rst_i || fack) begin
            fault <= 1'b0;
        end else if (trip && (ramp || run)) begin
            fault <= 1'b1;
        end
    end
    // Comparison that counts and reports a mismatch.
    task automatic chk(input string name, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask
    // One classic Wishbone cycle; read data lands in rd at the ack edge.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk("ack", 32'h1, {31'h0, ack});
    endtask
    // Waits a bounded time for an output: 0 run, 1 ack pulse, 2 ramp.
    task automatic wait_hi(input int k);
        int n;
        logic [2:0] v;
        n = 0;
        v = {ramp, fack, run};
        while (v[k] !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
            v = {ramp, fack, run};
        end
        chk("output awaited", 32'h1, {31'h0, v[k]});
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Clock of 8 ns period.
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Cuts a hang short.
    initial begin
        #400000;
        n_mismatch++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        {rst_i, cyc, stb, we, on, trip, adr, wdat, shaft} = '0;
        line_ok = 1'b1;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, `RC_OFS_CTRL, 0); chk("ctrl", 32'h1, rd);
        bus(0, `RC_OFS_LIMIT, 0); chk("limit", 32'h3, rd);
        bus(0, 8'h20, 0); chk("unmapped", 32'h0, rd);
        bus(1, `RC_OFS_LIMIT, 32'hf);
        bus(0, `RC_OFS_LIMIT, 0); chk("limit clamp", 32'ha, rd);
        bus(1, `RC_OFS_CTRL, 32'h7);
        bus(0, `RC_OFS_CTRL, 0); chk("mode 7", 32'h1, rd);
        bus(1, `RC_OFS_CTRL, 32'h3);
        bus(1, `RC_OFS_LIMIT, 32'h2);
        bus(1, `RC_OFS_IRQ_MASK, 32'hf);
        on <= 1'b1;
        wait_hi(2);
        repeat (20) @(posedge clk_i);
        bus(0, `RC_OFS_STATUS, 0); chk("state run", 32'h6, rd & 32'h7);
        chk("irq set", 32'h1, {31'h0, irq});
        bus(1, `RC_OFS_IRQ_STS, 32'hf);
        chk("irq clear", 32'h0, {31'h0, irq});
        trip <= 1'b1;
        wait_hi(1);
        repeat (300) @(posedge clk_i);
        bus(0, `RC_OFS_STATUS, 0); chk("locked", 32'h7, rd & 32'h7);
        chk("run locked", 32'h0, {31'h0, run});
        bus(0, `RC_OFS_IRQ_STS, 0); chk("lock irq", 32'h4, rd & 32'h4);
        trip <= 1'b0;
        on <= 1'b0;
        repeat (8) @(posedge clk_i);
        on <= 1'b1;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_hi(1);
        repeat (30) @(posedge clk_i);
        chk("mode 1 no start", 32'h0, {31'h0, run});
        for (int i = 0; i < 3; i++) begin
            on <= 1'b0;
            bus(1, `RC_OFS_CTRL, 3 | (catch_t[i] << 4) | (brk_t[i] << 8));
            shaft <= shaft_t[i];
            repeat (8) @(posedge clk_i);
            on <= 1'b1;
            s_srch = 1'b0;
            s_rev = 1'b0;
            for (int n = 0; n < 200 && ramp !== 1'b1; n++) begin
                @(posedge clk_i);
                s_srch |= srch;
                s_rev |= rev;
            end
            chk("ramp", 32'h1, {31'h0, ramp});
            chk("search", 32'(brk_t[i] == 0), {31'h0, s_srch});
            chk("reverse", 32'(i == 0), {31'h0, s_rev});
            repeat (20) @(posedge clk_i);
        end
        line_ok <= 1'b0;
        repeat (10) @(posedge clk_i);
        line_ok <= 1'b1;
        repeat (10) @(posedge clk_i);
        bus(0, `RC_OFS_IRQ_STS, 0); chk("uv irq", 32'h8, rd & 32'h8);
        tally_and_finish();
    end
endmodule
`default_nettype wire
